// ===== hdl/ccpw_top.sv
// Capture/compare/PWM control unit with enhanced output stage.
// Assumes timers, comparators and converter run on clk_i; pins are async.
// Behaviour
// R1 - Capture on falling, rising, 4th, 16th rising edge
// R2 - Mode 0010 toggles pin on compare match
// R3 - Modes 1000/1001 preset pin, then set/clear
// R4 - Mode 1010 flags only, pin back to port
// R5 - Mode 1011 resets timer, flags, starts conversion
// R6 - Mode 0000 off and resets state; reserved codes
// R7 - Modes 11xx are PWM; low bits set polarity
// R8 - Config 00 single, 10 half-bridge with dead-band
// R9 - Config 01 forward, 11 reverse full-bridge
// R10 - Non-PWM modes use pin A only
// R11 - Duty is ten bits: two low, eight high
// R12 - Time base chosen from timers 2, 4, 6
// R13 - Shutdown event sets status and forces states
// R14 - Shutdown source code selects comparators and pin
// R15 - Pins A and C shutdown state: 0, 1, off
// R16 - Pins B and D shutdown state likewise
// R17 - Auto restart clears status when source gone
// R18 - Delay active-going edges by delay count
// R19 - Steering updates at period or at once
// R20 - Steer bits route PWM to each pin
// R21 - Steering only in PWM single-output config
// R22 - Comparator shutdown resynchronised to timer 1
// R23 - Status set keeps pins in shutdown state
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "ccpw_regs.svh"
module ccpw_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic [15:0] tmr1_count_i,
    input  wire logic        tmr1_tick_i,
    input  wire logic [9:0]  tmr2_base_i,
    input  wire logic        tmr2_period_i,
    input  wire logic [9:0]  tmr4_base_i,
    input  wire logic        tmr4_period_i,
    input  wire logic [9:0]  tmr6_base_i,
    input  wire logic        tmr6_period_i,
    input  wire logic        adc_enabled_i,
    input  wire logic        comparator_sync_enable_i,
    input  wire logic        cap_pin_i,
    input  wire logic        comp1_i,
    input  wire logic        comp2_i,
    input  wire logic        int_pin_i,
    output logic      [3:0]  pin_out_o,
    output logic      [3:0]  pin_oe_o,
    output logic      [3:0]  pin_own_o,
    output logic             unit_interrupt_flag_o,
    output logic             timer_reset_o,
    output logic             adc_start_o
);
    ccpw_pkg::ccpw_state_type s_reg;
    ccpw_pkg::ccpw_state_type s_next;

    logic [3:0] pins_s;
    logic       cap_s;
    logic       c1_s;
    logic       c2_s;
    logic       int_s;
    logic       access;
    logic       wr;
    logic [3:0] mode;
    logic [1:0] cfg;
    logic       pwm_mode;
    logic       mode_chg;
    logic [9:0] tb_base;
    logic       tb_period;
    logic       sd_evt;
    logic       db_a;
    logic       db_b;
    logic       match_evt;

    // Shutdown drive of a pin pair: {enable, level}
    function automatic logic [1:0] sd_drive(input logic [1:0] pss);
        sd_drive = pss[1] ? 2'h0 : {1'h1, pss[0]}; // [R15] [R16]
    endfunction : sd_drive

    ccpw_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({int_pin_i, comp2_i, comp1_i, cap_pin_i}),
        .sync_o  (pins_s)
    );

    assign cap_s = pins_s[0];
    assign c1_s  = pins_s[1];
    assign c2_s  = pins_s[2];
    assign int_s = pins_s[3];

    assign access   = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign wr       = access & wb_we_i & wb_sel_i[0];
    assign mode     = s_reg.mode_ctl[3:0];
    assign cfg      = s_reg.mode_ctl[7:6];
    assign pwm_mode = (mode[3:2] == `CCPW_GRP_PWM); // [R7]
    assign mode_chg = (mode != s_reg.mode_q);
    assign match_evt = (tmr1_count_i == {s_reg.val_hi, s_reg.val_lo})
                       & ~s_reg.match_q & ~mode_chg;

    always_comb begin
        case (s_reg.tmr_sel[1:0]) // [R12]
            `CCPW_TB_TMR2: begin
                tb_base   = tmr2_base_i;
                tb_period = tmr2_period_i;
            end
            `CCPW_TB_TMR4: begin
                tb_base   = tmr4_base_i;
                tb_period = tmr4_period_i;
            end
            `CCPW_TB_TMR6: begin
                tb_base   = tmr6_base_i;
                tb_period = tmr6_period_i;
            end
            default: begin
                tb_base   = 10'h000;
                tb_period = 1'h0;
            end
        endcase
    end

    // Comparators either direct or as last sampled on the timer 1 tick
    always_comb begin
        logic c1e;
        logic c2e;
        c1e = comparator_sync_enable_i ? s_reg.c1_t1 : c1_s; // [R22]
        c2e = comparator_sync_enable_i ? s_reg.c2_t1 : c2_s;
        sd_evt = (s_reg.ashut[4] & c1e) | (s_reg.ashut[5] & c2e)
                 | (s_reg.ashut[6] & ~int_s); // [R14]
    end

    ccpw_deadband u_db_a (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (~pwm_mode),
        .level_i (s_reg.pwm_raw),
        .delay_i (s_reg.epwm[6:0]),
        .level_o (db_a)
    );

    ccpw_deadband u_db_b (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (~pwm_mode | (cfg != `CCPW_CFG_HALF)),
        .level_i (~s_reg.pwm_raw),
        .delay_i (s_reg.epwm[6:0]),
        .level_o (db_b)
    );

    always_comb begin
        logic       cap_evt;
        logic [3:0] act;
        logic [3:0] own;
        logic [3:0] polv;
        logic [1:0] ac;
        logic [1:0] bd;
        cap_evt = 1'h0;
        act     = 4'h0;
        own     = 4'h0;
        polv    = {mode[0], mode[1], mode[0], mode[1]}; // [R7]
        ac      = sd_drive(s_reg.ashut[3:2]);
        bd      = sd_drive(s_reg.ashut[1:0]);
        s_next  = s_reg;
        s_next.ack     = access;
        s_next.tmr_rst = 1'h0;
        s_next.adc_go  = 1'h0;
        s_next.mode_q  = mode;
        s_next.cap_q   = cap_s;
        s_next.match_q = (tmr1_count_i == {s_reg.val_hi, s_reg.val_lo});
        if (tmr1_tick_i) begin
            s_next.c1_t1 = c1_s; // [R22]
            s_next.c2_t1 = c2_s;
        end
        // Register reads
        if (access) begin
            case (wb_adr_i)
                `CCPW_OFS_MODE:   s_next.rdata = s_reg.mode_ctl;
                `CCPW_OFS_TMRSEL: s_next.rdata = s_reg.tmr_sel;
                `CCPW_OFS_ASHUT:  s_next.rdata = s_reg.ashut;
                `CCPW_OFS_EPWM:   s_next.rdata = s_reg.epwm;
                `CCPW_OFS_STEER:  s_next.rdata = {3'h0, s_reg.steer};
                `CCPW_OFS_VAL_LO: s_next.rdata = s_reg.val_lo;
                `CCPW_OFS_VAL_HI: s_next.rdata = s_reg.val_hi;
                `CCPW_OFS_STATUS: s_next.rdata = {7'h00, s_reg.flag};
                default:          s_next.rdata = 8'h00;
            endcase
        end
        // Register writes
        if (wr) begin
            case (wb_adr_i)
                `CCPW_OFS_MODE:   s_next.mode_ctl = wb_dat_i[7:0];
                `CCPW_OFS_TMRSEL: s_next.tmr_sel  = wb_dat_i[7:0];
                `CCPW_OFS_ASHUT:  s_next.ashut    = wb_dat_i[7:0];
                `CCPW_OFS_EPWM:   s_next.epwm     = wb_dat_i[7:0];
                `CCPW_OFS_STEER:  s_next.steer    = wb_dat_i[4:0];
                `CCPW_OFS_VAL_LO: s_next.val_lo   = wb_dat_i[7:0];
                `CCPW_OFS_VAL_HI: s_next.val_hi   = wb_dat_i[7:0];
                `CCPW_OFS_STATUS: begin
                    if (wb_dat_i[`CCPW_FLAG_BIT]) begin
                        s_next.flag = 1'h0;
                    end
                end
                default: ;
            endcase
        end
        // Capture and compare
        if (mode == `CCPW_MODE_OFF || mode == 4'h1 || mode == 4'h3) begin
            s_next.presc    = 4'h0; // [R6]
            s_next.cmp_out  = 1'h0;
        end else if (mode_chg) begin
            s_next.presc   = 4'h0;
            s_next.cmp_out = (mode == `CCPW_MODE_CMP_CLR); // [R3]
        end else begin
            case (mode)
                `CCPW_MODE_CAP_FALL: cap_evt = ~cap_s & s_reg.cap_q; // [R1]
                `CCPW_MODE_CAP_RISE: cap_evt = cap_s & ~s_reg.cap_q; // [R1]
                `CCPW_MODE_CAP_R4, `CCPW_MODE_CAP_R16: begin
                    if (cap_s & ~s_reg.cap_q) begin
                        if (s_reg.presc == (mode[0] ? `CCPW_PRESC_R16
                                                     : `CCPW_PRESC_R4)) begin
                            cap_evt      = 1'h1; // [R1]
                            s_next.presc = 4'h0;
                        end else begin
                            s_next.presc = s_reg.presc + 4'h1;
                        end
                    end
                end
                `CCPW_MODE_TOGGLE: begin
                    if (match_evt) begin
                        s_next.cmp_out = ~s_reg.cmp_out; // [R2]
                        s_next.flag    = 1'h1;
                    end
                end
                `CCPW_MODE_CMP_SET, `CCPW_MODE_CMP_CLR: begin
                    if (match_evt) begin
                        s_next.cmp_out = ~mode[0]; // [R3]
                        s_next.flag    = 1'h1;
                    end
                end
                `CCPW_MODE_CMP_SOFT: begin
                    if (match_evt) begin
                        s_next.flag = 1'h1; // [R4]
                    end
                end
                `CCPW_MODE_SPECIAL: begin
                    if (match_evt) begin
                        s_next.flag    = 1'h1; // [R5]
                        s_next.tmr_rst = 1'h1;
                        s_next.adc_go  = adc_enabled_i;
                    end
                end
                default: ;
            endcase
        end
        if (cap_evt) begin
            s_next.val_lo = tmr1_count_i[7:0];
            s_next.val_hi = tmr1_count_i[15:8];
            s_next.flag   = 1'h1;
        end
        // PWM waveform from the selected time base
        if (!pwm_mode) begin
            s_next.pwm_raw  = 1'h0;
            s_next.duty_buf = 10'h000;
        end else if (tb_period) begin
            s_next.duty_buf = {s_reg.val_lo, s_reg.mode_ctl[5:4]}; // [R11]
            s_next.pwm_raw  = ({s_reg.val_lo, s_reg.mode_ctl[5:4]} != 10'h000);
        end else if (tb_base >= s_reg.duty_buf) begin
            s_next.pwm_raw = 1'h0;
        end
        if (!s_reg.steer[`CCPW_SYNC_BIT] || tb_period || !pwm_mode) begin
            s_next.steer_eff = s_reg.steer[3:0]; // [R19]
        end
        // Shutdown status: a new event wins over any clear
        if (pwm_mode && sd_evt) begin
            s_next.ashut[`CCPW_ASE_BIT] = 1'h1; // [R13]
        end else if (s_reg.epwm[`CCPW_RSEN_BIT] && !sd_evt
                     && !(wr && wb_adr_i == `CCPW_OFS_ASHUT)) begin
            s_next.ashut[`CCPW_ASE_BIT] = 1'h0; // [R17]
        end
        // Pin ownership and levels
        if (pwm_mode) begin
            case (cfg)
                `CCPW_CFG_SINGLE: begin
                    own = s_reg.steer_eff; // [R8] [R20] [R21]
                    act = {4{db_a}};
                end
                `CCPW_CFG_FULL_FWD: begin
                    own = 4'hF; // [R9]
                    act = {db_a, 2'h0, 1'h1};
                end
                `CCPW_CFG_HALF: begin
                    own = 4'h3; // [R8]
                    act = {2'h0, db_b, db_a};
                end
                default: begin
                    own = 4'hF; // [R9]
                    act = {1'h0, 1'h1, db_a, 1'h0};
                end
            endcase
            s_next.pin_own = own;
            if (s_reg.ashut[`CCPW_ASE_BIT]) begin
                s_next.pin_oe  = own & {bd[1], ac[1], bd[1], ac[1]}; // [R23]
                s_next.pin_out = own & {bd[1], ac[1], bd[1], ac[1]}
                                 & {bd[0], ac[0], bd[0], ac[0]};
            end else begin
                s_next.pin_oe  = own;
                s_next.pin_out = own & (act ^ polv);
            end
        end else if (mode[3:2] == `CCPW_GRP_CAPTURE) begin
            s_next.pin_own = 4'h1; // [R10]
            s_next.pin_oe  = 4'h0;
            s_next.pin_out = 4'h0;
        end else if (mode == `CCPW_MODE_TOGGLE || mode == `CCPW_MODE_CMP_SET
                     || mode == `CCPW_MODE_CMP_CLR
                     || mode == `CCPW_MODE_SPECIAL) begin
            s_next.pin_own = 4'h1; // [R10]
            s_next.pin_oe  = 4'h1;
            s_next.pin_out = {3'h0, s_reg.cmp_out};
        end else begin
            s_next.pin_own = 4'h0; // [R4] [R6]
            s_next.pin_oe  = 4'h0;
            s_next.pin_out = 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg          <= '0;
            s_reg.mode_ctl <= `CCPW_RST_CTL;
            s_reg.tmr_sel  <= `CCPW_RST_CTL;
            s_reg.ashut    <= `CCPW_RST_CTL;
            s_reg.epwm     <= `CCPW_RST_CTL;
            s_reg.steer    <= `CCPW_RST_STEER;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o              = s_reg.ack;
    assign wb_dat_o              = {24'h000000, s_reg.rdata};
    assign pin_out_o             = s_reg.pin_out;
    assign pin_oe_o              = s_reg.pin_oe;
    assign pin_own_o             = s_reg.pin_own;
    assign unit_interrupt_flag_o = s_reg.flag;
    assign timer_reset_o         = s_reg.tmr_rst;
    assign adc_start_o           = s_reg.adc_go;

    chk_capture_rise_flag: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        (mode == `CCPW_MODE_CAP_RISE && !mode_chg && cap_s && !s_reg.cap_q)
        |=> s_reg.flag && {s_reg.val_hi, s_reg.val_lo} == $past(tmr1_count_i))
        else $error("rising edge capture missed");

    chk_toggle_on_match: assert property ( // [R2]
        @(posedge clk_i) disable iff (rst_i)
        (mode == `CCPW_MODE_TOGGLE && match_evt)
        |=> s_reg.cmp_out != $past(s_reg.cmp_out)
            ##1 pin_out_o[0] == $past(s_reg.cmp_out))
        else $error("compare toggle not seen on pin");

    chk_set_on_match: assert property ( // [R3]
        @(posedge clk_i) disable iff (rst_i)
        (mode == `CCPW_MODE_CMP_SET && match_evt)
        |=> s_reg.cmp_out && s_reg.flag)
        else $error("compare set mode did not drive high");

    chk_soft_pin_free: assert property ( // [R4]
        @(posedge clk_i) disable iff (rst_i)
        (mode == `CCPW_MODE_CMP_SOFT)
        |=> pin_own_o == 4'h0 && pin_oe_o == 4'h0)
        else $error("soft interrupt mode holds the pin");

    chk_special_event: assert property ( // [R5]
        @(posedge clk_i) disable iff (rst_i)
        (mode == `CCPW_MODE_SPECIAL && match_evt)
        |=> timer_reset_o && adc_start_o == $past(adc_enabled_i)
            ##1 !timer_reset_o)
        else $error("special event trigger wrong");

    chk_off_releases: assert property ( // [R6]
        @(posedge clk_i) disable iff (rst_i)
        (mode == `CCPW_MODE_OFF) |=> pin_own_o == 4'h0 && !s_reg.cmp_out)
        else $error("off mode left state or pins");

    chk_non_pwm_pins: assert property ( // [R10]
        @(posedge clk_i) disable iff (rst_i)
        (!pwm_mode) |=> pin_own_o[3:1] == 3'h0)
        else $error("pins B to D taken outside PWM");

    chk_shutdown_set: assert property ( // [R13]
        @(posedge clk_i) disable iff (rst_i)
        (pwm_mode && sd_evt) |=> s_reg.ashut[`CCPW_ASE_BIT])
        else $error("shutdown event did not set status");

    chk_shutdown_sticky: assert property ( // [R23]
        @(posedge clk_i) disable iff (rst_i)
        (s_reg.ashut[`CCPW_ASE_BIT] && !s_reg.epwm[`CCPW_RSEN_BIT]
         && !(wr && wb_adr_i == `CCPW_OFS_ASHUT))
        |=> s_reg.ashut[`CCPW_ASE_BIT])
        else $error("shutdown status dropped without software");

    chk_restart_clears: assert property ( // [R17]
        @(posedge clk_i) disable iff (rst_i)
        (s_reg.ashut[`CCPW_ASE_BIT] && s_reg.epwm[`CCPW_RSEN_BIT] && !sd_evt
         && !(wr && wb_adr_i == `CCPW_OFS_ASHUT))
        |=> !s_reg.ashut[`CCPW_ASE_BIT])
        else $error("auto restart did not clear status");

    chk_shutdown_pins_ac: assert property ( // [R15]
        @(posedge clk_i) disable iff (rst_i)
        (pwm_mode && s_reg.ashut[`CCPW_ASE_BIT] && s_reg.ashut[3:2] == 2'h1
         && s_next.pin_own[0] && !mode_chg)
        |=> pin_oe_o[0] && pin_out_o[0])
        else $error("pin A shutdown level wrong");
endmodule : ccpw_top

// ===== hdl/ccpw_regs.svh
// Register offsets, field positions, reset values, mode codes and timing
// counts of the capture/compare/PWM control block.
// Assumes byte addresses on a 32-bit classic Wishbone bus.
`ifndef CCPW_REGS_SVH
`define CCPW_REGS_SVH

`define CCPW_OFS_MODE       8'h00
`define CCPW_OFS_TMRSEL     8'h04
`define CCPW_OFS_ASHUT      8'h08
`define CCPW_OFS_EPWM       8'h0C
`define CCPW_OFS_STEER      8'h10
`define CCPW_OFS_VAL_LO     8'h14
`define CCPW_OFS_VAL_HI     8'h18
`define CCPW_OFS_STATUS     8'h1C

`define CCPW_RST_CTL        8'h00
`define CCPW_RST_STEER      5'h01

`define CCPW_ASE_BIT        7
`define CCPW_RSEN_BIT       7
`define CCPW_SYNC_BIT       4
`define CCPW_FLAG_BIT       0

`define CCPW_MODE_OFF       4'h0
`define CCPW_MODE_TOGGLE    4'h2
`define CCPW_MODE_CAP_FALL  4'h4
`define CCPW_MODE_CAP_RISE  4'h5
`define CCPW_MODE_CAP_R4    4'h6
`define CCPW_MODE_CAP_R16   4'h7
`define CCPW_MODE_CMP_SET   4'h8
`define CCPW_MODE_CMP_CLR   4'h9
`define CCPW_MODE_CMP_SOFT  4'hA
`define CCPW_MODE_SPECIAL   4'hB
`define CCPW_GRP_CAPTURE    2'h1
`define CCPW_GRP_PWM        2'h3

`define CCPW_CFG_SINGLE     2'h0
`define CCPW_CFG_FULL_FWD   2'h1
`define CCPW_CFG_HALF       2'h2
`define CCPW_CFG_FULL_REV   2'h3

`define CCPW_TB_TMR2        2'h0
`define CCPW_TB_TMR4        2'h1
`define CCPW_TB_TMR6        2'h2

`define CCPW_PRESC_R4       4'h3
`define CCPW_PRESC_R16      4'hF

`define CCPW_CLK_PERIOD_NS  25
`define CCPW_DB_STEP_NS     25
`define CCPW_DB_STEP_CYC    (`CCPW_DB_STEP_NS / `CCPW_CLK_PERIOD_NS)

`endif

// ===== hdl/ccpw_pkg.sv
// State types of the capture/compare/PWM control block.
// Assumes ccpw_regs.svh is compiled with it.
package ccpw_pkg;

    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
    } ccpw_sync_state_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic       level;
    } ccpw_db_state_type;

    typedef struct packed {
        logic [7:0] mode_ctl;
        logic [7:0] tmr_sel;
        logic [7:0] ashut;
        logic [7:0] epwm;
        logic [4:0] steer;
        logic [7:0] val_lo;
        logic [7:0] val_hi;
        logic       flag;
        logic       ack;
        logic [7:0] rdata;
        logic [3:0] mode_q;
        logic [3:0] presc;
        logic       cmp_out;
        logic       match_q;
        logic       cap_q;
        logic [9:0] duty_buf;
        logic       pwm_raw;
        logic [3:0] steer_eff;
        logic       c1_t1;
        logic       c2_t1;
        logic       tmr_rst;
        logic       adc_go;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic [3:0] pin_own;
    } ccpw_state_type;

endpackage : ccpw_pkg

// ===== hdl/ccpw_sync.sv
// Two-stage synchroniser for the four asynchronous pin inputs.
// Assumes the inputs may change at any time relative to clk_i.
`timescale 1ns/1ps
module ccpw_sync (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] async_i,
    output logic      [3:0] sync_o
);
    ccpw_pkg::ccpw_sync_state_type s_reg;
    ccpw_pkg::ccpw_sync_state_type s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.meta = async_i;
        s_next.sync = s_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_o = s_reg.sync;
endmodule : ccpw_sync

// ===== hdl/ccpw_deadband.sv
// Delays the active-going edge of a PWM level; inactive edges pass at once.
// Assumes delay_i counts instruction cycles, one per clk_i cycle.
`timescale 1ns/1ps
`include "ccpw_regs.svh"
module ccpw_deadband (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clear_i,
    input  wire logic       level_i,
    input  wire logic [6:0] delay_i,
    output logic            level_o
);
    ccpw_pkg::ccpw_db_state_type s_reg;
    ccpw_pkg::ccpw_db_state_type s_next;
    logic [7:0]                  target;

    assign target = 8'({1'h0, delay_i} * `CCPW_DB_STEP_CYC);

    always_comb begin
        s_next = s_reg;
        if (clear_i || !level_i) begin
            s_next.cnt   = 8'h00;
            s_next.level = 1'h0;
        end else if (!s_reg.level) begin
            if (s_reg.cnt >= target) begin
                s_next.level = 1'h1; // [R18]
            end else begin
                s_next.cnt = s_reg.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_o = s_reg.level;

    chk_delay_not_early: assert property ( // [R18]
        @(posedge clk_i) disable iff (rst_i)
        (level_i && !clear_i && !s_reg.level && s_reg.cnt < target)
        |=> !s_reg.level)
        else $error("active edge passed before the delay count");
endmodule : ccpw_deadband

// ===== dv/ccpw_pin_model.sv
// Model of the pins and switch drivers beyond the control unit.
// Assumes pin_oe_i is high while the unit drives the pin.
`timescale 1ns/1ps
module ccpw_pin_model (
    input  wire logic [3:0] pin_out_i,
    input  wire logic [3:0] pin_oe_i,
    output logic      [3:0] pad_o
);
    // Released pins fall to the pull-down level, keeping switches off
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad_o[i] = pin_oe_i[i] ? pin_out_i[i] : 1'b0;
        end
    end
endmodule : ccpw_pin_model

// ===== dv/tb_ccpw_top.sv
// Self-checking bench for the capture/compare/PWM control unit.
// Assumes the pin model pulls released pins low.
`timescale 1ns/1ps
module tb_ccpw_top;
    logic        clk_i = 0;
    logic        rst_i = 1;
    logic        cyc = 0, stb = 0, we = 0, adc = 0, c1 = 0, cp = 0, cs = 0;
    logic [7:0]  adr = 8'h00, cnt = 8'h00;
    logic [31:0] dat = 32'h0, q, rd, d;
    logic [3:0]  po, oe, own, pad;
    logic        ack, flag, trst, adcs;
    int          errors = 0, samples_checked = 0, seed = 37730, n;
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) cnt <= cnt + 8'h01;
    always @(posedge clk_i) cp <= $random(seed);
    ccpw_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(4'hF),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .tmr1_count_i({8'h00, cnt}), .tmr1_tick_i(cnt[1:0] == 2'h0),
        .tmr2_base_i({4'h0, cnt[5:0]}), .tmr2_period_i(cnt[5:0] == 6'h00),
        .tmr4_base_i({2'h0, cnt}), .tmr4_period_i(cnt == 8'h00),
        .tmr6_base_i({4'h0, cnt[5:0]}), .tmr6_period_i(cnt[5:0] == 6'h00),
        .adc_enabled_i(adc), .comparator_sync_enable_i(cs),
        .cap_pin_i(cp), .comp1_i(c1), .comp2_i(1'b0), .int_pin_i(1'b1),
        .pin_out_o(po), .pin_oe_o(oe), .pin_own_o(own),
        .unit_interrupt_flag_o(flag), .timer_reset_o(trst),
        .adc_start_o(adcs));
    ccpw_pin_model u_pins (.pin_out_i(po), .pin_oe_i(oe), .pad_o(pad));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, v};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rd;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rdchk
    task automatic wflag;
        n = 0;
        while (flag !== 1'b1 && n++ < 600) @(negedge clk_i);
        if (n > 600) errors++;
        repeat (3) @(negedge clk_i);
    endtask : wflag
    task automatic finish_test;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(8'h10, 32'h01);
        for (int i = 0; i < 4; i++) begin
            rdchk(8'(i * 4), 32'h00);
        end
        repeat (8) begin
            d = $random(seed);
            wb(1'b1, 8'h14, d);
            rdchk(8'h14, {24'h0, d[7:0]});
        end
        wb(1'b1, 8'h40, 32'hFF);
        rdchk(8'h40, 32'h00);
        $display("test registers done");
        wb(1'b1, 8'h14, 32'h40);
        wb(1'b1, 8'h18, 32'h00);
        adc <= 1'b1;
        wb(1'b1, 8'h00, 32'h0B);
        n = 0;
        while (trst !== 1'b1 && n++ < 600) @(negedge clk_i);
        chk({trst, adcs, flag}, 32'h7);
        wb(1'b1, 8'h1C, 32'h01);
        rdchk(8'h1C, 32'h00);
        $display("test special event done");
        wb(1'b1, 8'h00, 32'h08);
        repeat (3) @(negedge clk_i);
        chk({own[0], oe[0], po[0]}, 32'h6);
        wflag;
        chk({flag, po[0]}, 32'h3);
        chk(own[3:1], 32'h0);
        $display("test compare done");
        wb(1'b1, 8'h08, 32'h14);
        wb(1'b1, 8'h00, 32'h0C);
        {c1, cs} <= 2'b11;
        repeat (8) @(negedge clk_i);
        rdchk(8'h08, 32'h94);
        chk({oe[0], po[0]}, 32'h3);
        c1 <= 1'b0;
        repeat (10) @(negedge clk_i);
        chk({oe[0], po[0]}, 32'h3);
        wb(1'b1, 8'h08, 32'h98);
        repeat (4) @(negedge clk_i);
        chk({own[0], oe[0], pad[0]}, 32'h4);
        wb(1'b1, 8'h0C, 32'h80);
        repeat (4) @(negedge clk_i);
        rdchk(8'h08, 32'h18);
        $display("test shutdown done");
        wb(1'b1, 8'h00, 32'h05);
        wb(1'b1, 8'h1C, 32'h01);
        wflag;
        chk({flag, own, oe}, 32'h110);
        wb(1'b1, 8'h00, 32'h00);
        wb(1'b1, 8'h14, 32'h40);
        wb(1'b1, 8'h18, 32'h00);
        wb(1'b1, 8'h1C, 32'h01);
        wb(1'b1, 8'h00, 32'h02);
        wflag;
        chk({own[0], oe[0], po[0]}, 32'h7);
        wb(1'b1, 8'h1C, 32'h01);
        wflag;
        chk(po[0], 32'h0);
        wb(1'b1, 8'h00, 32'h0A);
        wb(1'b1, 8'h1C, 32'h01);
        wflag;
        chk({flag, own[0], oe[0]}, 32'h4);
        $display("test capture and compare modes done");
        wb(1'b1, 8'h00, 32'h4E);
        repeat (4) @(negedge clk_i);
        chk({own, po[2:0]}, 32'h7C);
        wb(1'b1, 8'h00, 32'hCC);
        repeat (4) @(negedge clk_i);
        chk({own, po[3:2], po[0]}, 32'h7A);
        wb(1'b1, 8'h00, 32'h8C);
        repeat (70) @(negedge clk_i);
        chk({own, po[1:0]}, 32'h0D);
        wb(1'b1, 8'h0C, 32'h00);
        wb(1'b1, 8'h08, 32'h81);
        repeat (4) @(negedge clk_i);
        chk({oe[1:0], po[1:0]}, 32'hE);
        $display("test bridge modes done");
        finish_test;
    end
endmodule : tb_ccpw_top
